//--- bsd_dev.sv
// device end: bank selection, bank switching, decode area and reading test
`timescale 1ns/100ps
`include "bsd_consts.svh"
module bsd_dev (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  bsd_if.dev               lnk,
  output logic             scan_start_out,
  output logic [2:0]       scan_bank_out,
  input  wire logic        scan_done_in,
  input  wire logic        scan_ok_in,
  input  wire logic [9:0]  scan_ms_in,
  input  wire logic [31:0] scan_data_in,
  output logic [9:0]       area_x_lo_out,
  output logic [9:0]       area_x_hi_out,
  output logic [9:0]       area_y_lo_out,
  output logic [9:0]       area_y_hi_out,
  output logic             reading_out,
  output logic             switching_out
);
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [13:0] bcd_val(input logic [15:0] v);
    bcd_val = 14'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
  endfunction

  function automatic logic [7:0] dig(input logic [9:0] v, input int pos);
    dig = 8'h30 + 8'((v / (10 ** pos)) % 10);
  endfunction

  // next registered bank after cur, wrapping past 7 back to 1
  function automatic logic [2:0] next_bank(input logic [2:0] cur, input logic [7:0] vld,
                                           input logic [2:0] strt);
    logic [2:0] b;
    logic       found;
    b = cur;
    found = 1'b0;
    next_bank = strt;
    for (int i = 0; i < 7; i++) begin
      b = (b == `BSD_BANK_MAX) ? 3'h1 : 3'(b + 3'h1);
      if (!found && vld[b]) begin
        next_bank = b;
        found = 1'b1;
      end
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  bsd_pkg::bsd_state_type st_ff, nxt_st;
  logic [2:0]   bank_ff, nxt_bank;
  logic [2:0]   start_ff, nxt_start;
  logic         sw_en_ff, nxt_sw_en;
  logic [7:0]   valid_ff, nxt_valid;
  logic [13:0]  retry_ff [8];
  logic [13:0]  nxt_retry [8];
  logic [9:0]   marg_ff [8][4];
  logic [9:0]   nxt_marg [8][4];
  logic [2:0]   cur_ff, nxt_cur;
  logic [13:0]  tries_ff, nxt_tries;
  logic         wait_ff, nxt_wait;
  logic         scan_ff, nxt_scan;
  logic [3:0]   grp_ff, nxt_grp;
  logic [3:0]   okn_ff, nxt_okn;
  logic [9:0]   tmin_ff, nxt_tmin;
  logic [9:0]   tmax_ff, nxt_tmax;
  logic [`BSD_LINE_W-1:0] line_ff, nxt_line;
  logic [5:0]   len_ff, nxt_len;

  logic         take;
  logic [13:0]  num;
  logic [2:0]   eff_bank;
  logic [2:0]   arg_bank;
  logic         arg_ok;
  logic [9:0]   ms;
  logic [9:0]   rate;

  assign lnk.cmd_ready = (len_ff == 6'h00);
  assign take          = lnk.cmd_valid && lnk.cmd_ready;
  assign num           = bcd_val(lnk.cmd_val);
  assign arg_bank      = lnk.cmd_val[2:0];
  assign arg_ok        = (lnk.cmd_sel == 4'h0) && (lnk.cmd_val[15:3] == 13'h0) && (arg_bank != 3'h0);
  assign eff_bank      = valid_ff[bank_ff] ? bank_ff : 3'h0;
  assign ms            = (scan_ms_in > `BSD_MS_SAT) ? `BSD_MS_SAT : scan_ms_in;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st    = st_ff;
    nxt_bank  = bank_ff;
    nxt_start = start_ff;
    nxt_sw_en = sw_en_ff;
    nxt_valid = valid_ff;
    nxt_retry = retry_ff;
    nxt_marg  = marg_ff;
    nxt_cur   = cur_ff;
    nxt_tries = tries_ff;
    nxt_wait  = wait_ff;
    nxt_scan  = 1'b0;
    nxt_grp   = grp_ff;
    nxt_okn   = okn_ff;
    nxt_tmin  = tmin_ff;
    nxt_tmax  = tmax_ff;
    nxt_line  = {line_ff[`BSD_LINE_W-9:0], 8'h00};
    nxt_len   = (len_ff != 6'h00) ? 6'(len_ff - 6'h01) : 6'h00;
    rate      = 10'(okn_ff * 10);
    // scan sequencing; one scan lasts one decode timeout in the engine
    if (st_ff != bsd_pkg::BSD_IDLE) begin
      if (!wait_ff) begin
        nxt_scan = 1'b1;
        nxt_wait = 1'b1;
      end else if (scan_done_in) begin
        nxt_wait = 1'b0;
        if (st_ff == bsd_pkg::BSD_TEST) begin
          nxt_grp = 4'(grp_ff + 4'h1);
          if (scan_ok_in) begin
            nxt_okn = 4'(okn_ff + 4'h1);
            if (ms < tmin_ff) nxt_tmin = ms;
            if (ms > tmax_ff) nxt_tmax = ms;
          end
          if (grp_ff == `BSD_TEST_GROUP) begin
            rate     = scan_ok_in ? 10'(nxt_okn * 10) : rate;
            nxt_line = {"BANK ", dig({7'h0, cur_ff}, 0), ":RATE ", dig(rate, 2), dig(rate, 1), dig(rate, 0),
                        "[%]:TIME ", dig(nxt_tmin, 2), dig(nxt_tmin, 1), dig(nxt_tmin, 0), " - ",
                        dig(nxt_tmax, 2), dig(nxt_tmax, 1), dig(nxt_tmax, 0), "[ms]:", scan_data_in, 8'h0d};
            nxt_len  = `BSD_LINE_CHARS;
            nxt_grp  = 4'h0;
            nxt_okn  = 4'h0;
            nxt_tmin = `BSD_MS_SAT;
            nxt_tmax = 10'h000;
          end
        end else if (scan_ok_in && !sw_en_ff) begin
          nxt_st = bsd_pkg::BSD_IDLE;
        end
        if (sw_en_ff && !(st_ff == bsd_pkg::BSD_READ && scan_ok_in)) begin
          nxt_tries = 14'(tries_ff + 14'h1);
          if (nxt_tries >= retry_ff[cur_ff]) begin
            nxt_tries = 14'h0;
            nxt_cur   = next_bank(cur_ff, valid_ff, start_ff);
          end
        end else if (sw_en_ff) begin
          nxt_st = bsd_pkg::BSD_IDLE;
        end
      end
    end
    if (take) begin
      case (lnk.cmd_code)
        bsd_pkg::BSD_SELECT_BANK_CMD: begin
          if (arg_ok) nxt_bank = arg_bank;
        end
        bsd_pkg::BSD_BANK_TRIGGER_CMD, bsd_pkg::BSD_TRIGGER_CMD: begin
          if (lnk.cmd_code == bsd_pkg::BSD_TRIGGER_CMD || arg_ok) begin
            if (lnk.cmd_code == bsd_pkg::BSD_BANK_TRIGGER_CMD) nxt_bank = arg_bank;
            nxt_st    = bsd_pkg::BSD_READ;
            nxt_wait  = 1'b0;
            nxt_tries = 14'h0;
            if (sw_en_ff)
              nxt_cur = valid_ff[start_ff] ? start_ff : next_bank(start_ff, valid_ff, start_ff);
            else
              nxt_cur = valid_ff[nxt_bank] ? nxt_bank : 3'h0;
          end
        end
        bsd_pkg::BSD_STOP_CMD, bsd_pkg::BSD_TEST_END_CMD: begin
          nxt_st = bsd_pkg::BSD_IDLE;
        end
        bsd_pkg::BSD_QUERY_BANK_CMD: begin
          nxt_line = {8'h30, dig({7'h0, bank_ff}, 0), 8'h0d, {(`BSD_LINE_W - 24){1'b0}}};
          nxt_len  = `BSD_QRY_CHARS;
        end
        bsd_pkg::BSD_INIT_ONE_BANK_CMD: begin
          if (arg_ok) begin
            // bank-held fields and a matching selected bank are touched here; switching enable and start stay
            nxt_valid[arg_bank] = 1'b0;
            nxt_retry[arg_bank] = `BSD_RETRY_RST;
            for (int s = 0; s < 4; s++) nxt_marg[arg_bank][s] = 10'h000;
            if (bank_ff == arg_bank) nxt_bank = 3'h0;
          end
        end
        bsd_pkg::BSD_INIT_EVERY_BANK_CMD: begin
          nxt_valid = 8'h00;
          nxt_bank  = 3'h0;
          for (int b = 0; b < 8; b++) begin
            nxt_retry[b] = `BSD_RETRY_RST;
            for (int s = 0; s < 4; s++) nxt_marg[b][s] = 10'h000;
          end
        end
        bsd_pkg::BSD_SWITCHING_CONTROL_CMD: begin
          if (lnk.cmd_val == 16'h0000 && lnk.cmd_sel == 4'h0) nxt_sw_en = 1'b0;
          if (lnk.cmd_val == 16'h0000 && lnk.cmd_sel == 4'h4) nxt_sw_en = 1'b1;
          if (lnk.cmd_sel == `BSD_SEL_RETRY && num != 14'h0 && num <= `BSD_RETRY_MAX && bank_ff != 3'h0)
            nxt_retry[bank_ff] = num;
          if (lnk.cmd_sel == `BSD_SEL_START && num != 14'h0 && num <= 14'(`BSD_BANK_MAX))
            nxt_start = num[2:0];
        end
        bsd_pkg::BSD_DECODE_MARGIN_CMD: begin
          if (lnk.cmd_sel == `BSD_SEL_ALL && lnk.cmd_val == 16'h0000) begin
            for (int s = 0; s < 4; s++) nxt_marg[bank_ff][s] = 10'h000;
          end else if (lnk.cmd_sel < `BSD_SEL_ALL &&
                       num <= 14'(lnk.cmd_sel[0] ? `BSD_HMARG_MAX : `BSD_VMARG_MAX)) begin
            nxt_marg[bank_ff][lnk.cmd_sel[1:0]] = num[9:0];
            if (bank_ff != 3'h0) nxt_valid[bank_ff] = 1'b1;
          end
        end
        bsd_pkg::BSD_BANK_PARAM_CMD: begin
          if (bank_ff != 3'h0) nxt_valid[bank_ff] = 1'b1;
        end
        bsd_pkg::BSD_TEST_START_CMD: begin
          nxt_st   = bsd_pkg::BSD_TEST;
          nxt_cur  = eff_bank;
          nxt_wait = 1'b0;
          nxt_grp  = 4'h0;
          nxt_okn  = 4'h0;
          nxt_tmin = `BSD_MS_SAT;
          nxt_tmax = 10'h000;
        end
        default: begin
        end
      endcase
    end
    nxt_valid[0] = 1'b0;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff    <= bsd_pkg::BSD_IDLE;
      bank_ff  <= 3'h0;
      start_ff <= `BSD_START_RST;
      sw_en_ff <= 1'b0;
      valid_ff <= 8'h00;
      for (int b = 0; b < 8; b++) begin
        retry_ff[b] <= `BSD_RETRY_RST;
        for (int s = 0; s < 4; s++) marg_ff[b][s] <= 10'h000;
      end
      cur_ff   <= 3'h0;
      tries_ff <= 14'h0;
      wait_ff  <= 1'b0;
      scan_ff  <= 1'b0;
      grp_ff   <= 4'h0;
      okn_ff   <= 4'h0;
      tmin_ff  <= `BSD_MS_SAT;
      tmax_ff  <= 10'h000;
      line_ff  <= '0;
      len_ff   <= 6'h00;
    end else begin
      st_ff    <= nxt_st;
      bank_ff  <= nxt_bank;
      start_ff <= nxt_start;
      sw_en_ff <= nxt_sw_en;
      valid_ff <= nxt_valid;
      retry_ff <= nxt_retry;
      marg_ff  <= nxt_marg;
      cur_ff   <= nxt_cur;
      tries_ff <= nxt_tries;
      wait_ff  <= nxt_wait;
      scan_ff  <= nxt_scan;
      grp_ff   <= nxt_grp;
      okn_ff   <= nxt_okn;
      tmin_ff  <= nxt_tmin;
      tmax_ff  <= nxt_tmax;
      line_ff  <= nxt_line;
      len_ff   <= nxt_len;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign lnk.rsp_valid  = (len_ff != 6'h00);
  assign lnk.rsp_data   = line_ff[`BSD_LINE_W-1 -: 8];
  assign scan_start_out = scan_ff;
  assign scan_bank_out  = cur_ff;
  assign reading_out    = (st_ff != bsd_pkg::BSD_IDLE);
  assign switching_out  = sw_en_ff;
  assign area_y_lo_out  = marg_ff[cur_ff][0];
  assign area_x_hi_out  = 10'(`BSD_IMG_W_MAX - marg_ff[cur_ff][1]);
  assign area_y_hi_out  = 10'(`BSD_IMG_H_MAX - marg_ff[cur_ff][2]);
  assign area_x_lo_out  = marg_ff[cur_ff][3];
endmodule

//--- bsd_consts.svh
// constants of the bank switching and decode area control link
`ifndef BSD_CONSTS_SVH
`define BSD_CONSTS_SVH
`define BSD_BANK_MAX     3'h7
`define BSD_START_RST    3'h1
`define BSD_RETRY_RST    14'h0001
`define BSD_RETRY_MAX    14'h270f
`define BSD_VMARG_MAX    10'h1df
`define BSD_HMARG_MAX    10'h27f
`define BSD_IMG_W_MAX    10'h27f
`define BSD_IMG_H_MAX    10'h1df
`define BSD_TEST_GROUP   4'h9
`define BSD_MS_SAT       10'h3e7
`define BSD_LINE_W       344
`define BSD_LINE_CHARS   6'h2b
`define BSD_QRY_CHARS    6'h03
`define BSD_SEL_TOP      4'h0
`define BSD_SEL_RIGHT    4'h1
`define BSD_SEL_BOTTOM   4'h2
`define BSD_SEL_LEFT     4'h3
`define BSD_SEL_ALL      4'h4
`define BSD_SEL_RETRY    4'h1
`define BSD_SEL_START    4'h2
`define BSD_REG_CMD      2'h0
`define BSD_REG_STATUS   2'h1
`define BSD_REG_RXDATA   2'h2
`endif

//--- bsd_pkg.sv
// types shared by both ends of the bank control link
package bsd_pkg;
  typedef enum logic [3:0] {
    BSD_SELECT_BANK_CMD,
    BSD_BANK_TRIGGER_CMD,
    BSD_TRIGGER_CMD,
    BSD_STOP_CMD,
    BSD_QUERY_BANK_CMD,
    BSD_INIT_ONE_BANK_CMD,
    BSD_INIT_EVERY_BANK_CMD,
    BSD_SWITCHING_CONTROL_CMD,
    BSD_DECODE_MARGIN_CMD,
    BSD_BANK_PARAM_CMD,
    BSD_TEST_START_CMD,
    BSD_TEST_END_CMD
  } bsd_cmd_type;
  typedef enum logic [1:0] {
    BSD_IDLE,
    BSD_READ,
    BSD_TEST
  } bsd_state_type;
endpackage

//--- bsd_if.sv
// command and reply link between host controller and bank control device
`timescale 1ns/100ps
interface bsd_if;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [3:0]  cmd_code;
  logic [3:0]  cmd_sel;
  logic [15:0] cmd_val;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  modport dev  (input cmd_valid, cmd_code, cmd_sel, cmd_val, output cmd_ready, rsp_valid, rsp_data);
  modport host (output cmd_valid, cmd_code, cmd_sel, cmd_val, input cmd_ready, rsp_valid, rsp_data);
endinterface

//--- bsd_host.sv
// host end: register port to command link, one command at a time, reply byte catch
`timescale 1ns/100ps
`include "bsd_consts.svh"
module bsd_host (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  bsd_if.host              lnk,
  input  wire logic [1:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out
);
  logic        pend_ff, nxt_pend;
  logic [23:0] cmd_ff, nxt_cmd;
  logic [7:0]  rx_ff, nxt_rx;
  logic        rxv_ff, nxt_rxv;
  logic        ovf_ff, nxt_ovf;
  logic [31:0] rd_ff, nxt_rd;

  always_comb begin
    nxt_pend = pend_ff;
    nxt_cmd  = cmd_ff;
    nxt_rx   = rx_ff;
    nxt_rxv  = rxv_ff;
    nxt_ovf  = ovf_ff;
    nxt_rd   = 32'h0;
    if (pend_ff && lnk.cmd_ready) nxt_pend = 1'b0;
    // writes while a command waits are dropped so the string order is kept
    if (wr_in && addr_in == `BSD_REG_CMD && !pend_ff) begin
      nxt_pend = 1'b1;
      nxt_cmd  = wdata_in[23:0];
      if (wdata_in[3:0] == bsd_pkg::BSD_DECODE_MARGIN_CMD && wdata_in[7:4] == `BSD_SEL_ALL)
        nxt_cmd[23:8] = 16'h0000;
    end
    if (rd_in) begin
      case (addr_in)
        `BSD_REG_CMD:    nxt_rd = {8'h00, cmd_ff};
        `BSD_REG_STATUS: nxt_rd = {29'h0, ovf_ff, rxv_ff, pend_ff};
        `BSD_REG_RXDATA: begin
          nxt_rd  = {24'h0, rx_ff};
          nxt_rxv = 1'b0;
          nxt_ovf = 1'b0;
        end
        default:         nxt_rd = 32'h0;
      endcase
    end
    // a byte arriving with the clearing read still wins
    if (lnk.rsp_valid) begin
      nxt_rx  = lnk.rsp_data;
      nxt_rxv = 1'b1;
      if (rxv_ff && !(rd_in && addr_in == `BSD_REG_RXDATA)) nxt_ovf = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_ff <= 1'b0;
      cmd_ff  <= 24'h0;
      rx_ff   <= 8'h00;
      rxv_ff  <= 1'b0;
      ovf_ff  <= 1'b0;
      rd_ff   <= 32'h0;
    end else begin
      pend_ff <= nxt_pend;
      cmd_ff  <= nxt_cmd;
      rx_ff   <= nxt_rx;
      rxv_ff  <= nxt_rxv;
      ovf_ff  <= nxt_ovf;
      rd_ff   <= nxt_rd;
    end
  end

  // stop command uses the same path as any other order
  assign lnk.cmd_valid = pend_ff;
  assign lnk.cmd_code  = cmd_ff[3:0];
  assign lnk.cmd_sel   = cmd_ff[7:4];
  assign lnk.cmd_val   = cmd_ff[23:8];
  assign rdata_out     = rd_ff;
endmodule

//--- bsd_link_asserts.sv
// checker for the command and reply link between the two ends
`timescale 1ns/100ps
module bsd_link_asserts (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [3:0]  cmd_code,
  input wire logic [3:0]  cmd_sel,
  input wire logic [15:0] cmd_val,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_data
);
  logic       take;
  logic       qry;
  logic       bok;
  logic [2:0] bank_ff;
  logic [2:0] nxt_bank_ff;
  logic [5:0] run_ff;
  logic [5:0] nxt_run_ff;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ****************************************
  // reference of the active bank
  // ****************************************
  assign take = cmd_valid && cmd_ready;
  assign qry  = take && cmd_code == 4'h4;
  // only bank 1..7 with a zero first parameter counts as a bank number
  assign bok  = cmd_sel == 4'h0 && cmd_val[15:3] == 13'h0000 && cmd_val[2:0] != 3'h0;
  always_comb begin
    nxt_bank_ff = bank_ff;
    nxt_run_ff  = rsp_valid ? run_ff + 6'h01 : 6'h00;
    if (take && bok && cmd_code <= 4'h1) begin
      nxt_bank_ff = cmd_val[2:0];
    end
    if (take && (cmd_code == 4'h6 || (cmd_code == 4'h5 && bok && cmd_val[2:0] == bank_ff))) begin
      nxt_bank_ff = 3'h0;
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bank_ff <= 3'h0;
      run_ff  <= 6'h00;
    end else begin
      bank_ff <= nxt_bank_ff;
      run_ff  <= nxt_run_ff;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  property p_query_len;
    qry |=> rsp_valid [*3] ##1 !rsp_valid;
  endproperty
  a_query_len: assert property (p_query_len) else $error("query reply length wrong");
  property p_query_text;
    qry |=> rsp_data == 8'h30 ##2 rsp_data == 8'h0d;
  endproperty
  a_query_text: assert property (p_query_text) else $error("query reply framing wrong");
  property p_query_digit;
    qry |=> ##1 rsp_data == 8'h30 + {5'h00, bank_ff};
  endproperty
  a_query_digit: assert property (p_query_digit) else $error("reported bank wrong");
  property p_ready_refuse;
    qry |=> !cmd_ready [*2];
  endproperty
  a_ready_refuse: assert property (p_ready_refuse) else $error("command taken during reply");
  property p_run_len;
    $fell(rsp_valid) |-> run_ff == 6'h03 || run_ff == 6'h2b;
  endproperty
  a_run_len: assert property (p_run_len) else $error("reply run length wrong");
  property p_line_cr;
    $fell(rsp_valid) |-> $past(rsp_data) == 8'h0d;
  endproperty
  a_line_cr: assert property (p_line_cr) else $error("reply not ended by carriage return");
  property p_ready_after;
    $fell(rsp_valid) |-> cmd_ready;
  endproperty
  a_ready_after: assert property (p_ready_after) else $error("link not ready after reply");
  property p_line_head;
    $rose(rsp_valid) && rsp_data == 8'h42 |-> ##1 rsp_data == 8'h41 ##1 rsp_data == 8'h4e ##1 rsp_data == 8'h4b;
  endproperty
  a_line_head: assert property (p_line_head) else $error("test line header wrong");
  property p_cmd_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code) && $stable(cmd_sel) && $stable(cmd_val);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped before taken");
endmodule

//--- tb_bank_switch_decode_area_ctrl.sv
// testbench: both ends joined, host driven through its register port
`timescale 1ns/100ps
module tb_bank_switch_decode_area_ctrl;
  logic        mclk_in = 1'b0;
  logic        rst_in, wr_in, rd_in, scan_start_out, scan_done_in, scan_ok_in;
  logic        reading_out, switching_out;
  logic [1:0]  addr_in;
  logic [2:0]  scan_bank_out, eng_cnt;
  logic [9:0]  scan_ms_in, x_lo, x_hi, y_lo, y_hi;
  logic [31:0] wdata_in, rdata_out, scan_data_in, d;
  logic [7:0]  rxq[$];
  logic [2:0]  bankq[$];
  int          err_count = 0;
  int          n_compared = 0;
  int          eng_n, ok_lim, i;
  bsd_if lnk_if ();
  bsd_host bsd_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .lnk(lnk_if), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
  bsd_dev bsd_dev_inst (.mclk_in(mclk_in), .rst_in(rst_in), .lnk(lnk_if), .scan_start_out(scan_start_out),
    .scan_bank_out(scan_bank_out), .scan_done_in(scan_done_in), .scan_ok_in(scan_ok_in),
    .scan_ms_in(scan_ms_in), .scan_data_in(scan_data_in), .area_x_lo_out(x_lo), .area_x_hi_out(x_hi),
    .area_y_lo_out(y_lo), .area_y_hi_out(y_hi), .reading_out(reading_out), .switching_out(switching_out));
  bsd_link_asserts bsd_link_asserts_inst (.mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid(lnk_if.cmd_valid),
    .cmd_ready(lnk_if.cmd_ready), .cmd_code(lnk_if.cmd_code), .cmd_sel(lnk_if.cmd_sel),
    .cmd_val(lnk_if.cmd_val), .rsp_valid(lnk_if.rsp_valid), .rsp_data(lnk_if.rsp_data));
  always #2.5 mclk_in = ~mclk_in;
  // ****************************************
  // engine stand-in and link monitor
  // ****************************************
  // every scan lasts four cycles; the first ok_lim of each ten succeed
  // the scan count restarts while ok_lim is zero, so a group lines up with the next test start
  always @(posedge mclk_in) begin
    if (rst_in === 1'b1) begin
      {scan_done_in, scan_ok_in, scan_ms_in, eng_cnt} <= '0;
      eng_n <= 0;
    end else begin
      scan_done_in <= 1'b0;
      if (lnk_if.rsp_valid === 1'b1) rxq.push_back(lnk_if.rsp_data);
      if (scan_start_out === 1'b1) begin
        bankq.push_back(scan_bank_out);
        eng_cnt <= 3'h4;
      end else if (eng_cnt != 3'h0) begin
        eng_cnt <= eng_cnt - 3'h1;
        if (eng_cnt == 3'h1) begin
          scan_done_in <= 1'b1;
          scan_ok_in   <= (eng_n % 10) < ok_lim;
          scan_ms_in   <= ((eng_n % 10) < ok_lim) ? 10'(12 + 3 * (eng_n % 10)) : 10'h014;
          eng_n        <= (ok_lim == 0) ? 0 : eng_n + 1;
        end
      end
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [3:0] s, input logic [15:0] v);
    int k;
    wr(2'h0, {8'h00, v, s, c});
    d = 32'h1;
    for (k = 0; k < 20 && d[0] !== 1'b0; k++) rd(2'h1, d);
    chk(d & 32'h1, 32'h0);
  endtask
  task automatic wq(input int n, input bit rx);
    int k;
    for (k = 0; k < 3000 && (rx ? rxq.size() : bankq.size()) < n; k++) @(posedge mclk_in);
    if (k == 3000) chk(32'h0, 32'(n));
  endtask
  task automatic chk_s(input string s);
    chk(32'(rxq.size()), 32'(s.len()));
    foreach (rxq[k]) chk({24'h0, rxq[k]}, {24'h0, (k < s.len()) ? s[k] : 8'h00});
  endtask
  task automatic q(input int b);
    rxq.delete();
    cmd(4'h4, 4'h0, 16'h0000);
    wq(3, 1'b1);
    chk_s($sformatf("0%0d\r", b));
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    chk(32'h0, 32'h1);
    stop_test();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {wr_in, rd_in, addr_in, wdata_in} = '0;
    ok_lim       = 0;
    scan_data_in = 32'h41424344;
    rst_in       = 1'b1;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(2'h3, d);
    chk(d, 32'h0);
    q(0);
    rd(2'h1, d);
    chk(d, 32'h6);
    rd(2'h2, d);
    chk(d, 32'h0d);
    rd(2'h1, d);
    chk(d, 32'h0);
    $display("reset and query test done");
    cmd(4'h0, 4'h0, 16'h0003);
    cmd(4'h0, 4'h0, 16'h0005);
    q(5);
    cmd(4'h0, 4'h0, 16'h0008);
    cmd(4'h0, 4'h1, 16'h0002);
    q(5);
    cmd(4'h5, 4'h0, 16'h0005);
    q(0);
    cmd(4'h0, 4'h0, 16'h0002);
    cmd(4'h5, 4'h0, 16'h0004);
    q(2);
    cmd(4'h6, 4'h0, 16'h0000);
    q(0);
    $display("selection and init test done");
    cmd(4'h0, 4'h0, 16'h0001);
    cmd(4'h8, 4'h0, 16'h0100);
    cmd(4'h8, 4'h1, 16'h0070);
    cmd(4'h8, 4'h2, 16'h0025);
    cmd(4'h8, 4'h3, 16'h0125);
    cmd(4'h8, 4'h0, 16'h0480);
    bankq.delete();
    cmd(4'h1, 4'h0, 16'h0001);
    wq(1, 1'b0);
    @(posedge mclk_in);
    chk({x_lo, x_hi}, {10'h07d, 10'h239});
    chk({y_lo, y_hi}, {10'h064, 10'h1c6});
    chk({reading_out, scan_bank_out}, 32'h9);
    q(1);
    cmd(4'h3, 4'h0, 16'h0000);
    repeat (2) @(posedge mclk_in);
    chk(reading_out, 32'h0);
    $display("margin and bank trigger test done");
    cmd(4'h7, 4'h4, 16'h0000);
    cmd(4'h6, 4'h0, 16'h0000);
    chk(switching_out, 32'h1);
    cmd(4'h0, 4'h0, 16'h0001);
    cmd(4'h9, 4'h0, 16'h0000);
    cmd(4'h7, 4'h1, 16'h0002);
    cmd(4'h0, 4'h0, 16'h0002);
    cmd(4'h9, 4'h0, 16'h0000);
    cmd(4'h7, 4'h1, 16'h0001);
    cmd(4'h7, 4'h2, 16'h0002);
    bankq.delete();
    cmd(4'h2, 4'h0, 16'h0000);
    wq(5, 1'b0);
    cmd(4'h3, 4'h0, 16'h0000);
    // expected scan banks 2,1,1,2,1 packed three bits each
    for (i = 0; i < 5; i++) chk(bankq[i], 15'h144a >> (3 * i) & 15'h7);
    cmd(4'h7, 4'h0, 16'h0000);
    chk(switching_out, 32'h0);
    $display("bank switching test done");
    cmd(4'h0, 4'h0, 16'h0001);
    @(posedge mclk_in);
    ok_lim <= 7;
    rxq.delete();
    cmd(4'ha, 4'h0, 16'h0000);
    wq(43, 1'b1);
    cmd(4'hb, 4'h0, 16'h0000);
    chk_s("BANK 1:RATE 070[%]:TIME 012 - 030[ms]:ABCD\r");
    $display("reading test done");
    repeat (8) @(posedge mclk_in);
    ok_lim <= 0;
    cmd(4'h8, 4'h4, 16'h0000);
    bankq.delete();
    cmd(4'h1, 4'h0, 16'h0001);
    wq(1, 1'b0);
    @(posedge mclk_in);
    chk({x_lo, x_hi, y_lo}, {10'h000, 10'h27f, 10'h000});
    chk(y_hi, 32'h1df);
    cmd(4'h3, 4'h0, 16'h0000);
    $display("margin init test done");
    stop_test();
  end
endmodule
